// File: psda_map.svh
// register offsets, field positions, reset values and cycle counts
// Function
// - table address is table page above the 16-bit effective address.
// - table page top bit picks user (0) or configuration (1) memory.
// - remapped address is remap page above effective address bits 14..0.
// - program address bit 23 is zero for every remapped access.
// - remap only when address top bit and core control remap enable are set.
// - data space from 8000h upward maps onto the selected program page.
// - remap page picks one of 256 pages; its bit 0 is address bit 15.
// - program counter steps by two, low word and high byte side by side.
// - word low table read returns program bits 15..0 unchanged.
// - byte low table read returns upper byte if select is 1, else lower.
// - word high table read returns bits 23..16, high data byte zero.
// - byte high table read gives bits 23..16 on select 0, zero on 1.
// - remapped access is suspended while a table access is in progress.
// - outside repeat, moves add one cycle, other instructions add two.
// - in repeat, edge iterations add two cycles, others take one.
// - remapped read needs two program fetches and one or two extra cycles, except on inner repeat iterations (one fetch).
// - fetch address is zero, program counter bits 22..1, then zero.
`ifndef PSDA_MAP_SVH
`define PSDA_MAP_SVH

`define PSDA_OFS_TABLE_PAGE   4'h0
`define PSDA_OFS_REMAP_PAGE   4'h4
`define PSDA_OFS_CORE_CONTROL 4'h8
`define PSDA_OFS_STATUS       4'hC

`define PSDA_RST_TABLE_PAGE   8'h00
`define PSDA_RST_REMAP_PAGE   8'h00
`define PSDA_RST_REMAP_ENABLE 1'b0

`define PSDA_BIT_REMAP_ENABLE 2
`define PSDA_BIT_EA_TOP       15
`define PSDA_BIT_PAGE_TOP     7

`define PSDA_EXTRA_MOVE       2'h1
`define PSDA_EXTRA_OTHER      2'h2
`define PSDA_EXTRA_REP_EDGE   2'h2
`define PSDA_EXTRA_REP_INNER  2'h0

`define PSDA_LANE_LOW         3'h1
`define PSDA_LANE_MID         3'h2
`define PSDA_LANE_WORD        3'h3
`define PSDA_LANE_HIGH        3'h4
`define PSDA_LANE_NONE        3'h0

`endif

// File: psda_pkg.sv
// types shared by the program space data access bridge
package psda_pkg;

  typedef enum logic [2:0] {
    OP_FETCH,
    OP_TABLE_READ_LOW,
    OP_TABLE_READ_HIGH,
    OP_TABLE_WRITE_LOW,
    OP_TABLE_WRITE_HIGH,
    OP_DATA_READ,
    OP_DATA_WRITE
  } psda_op_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_CAPTURE,
    ST_STALL
  } psda_fsm_t;

  typedef struct packed {
    logic        valid;
    psda_op_t    op;
    logic [15:0] ea;
    logic [22:0] pc;
    logic [15:0] wdata;
    logic        byte_mode;
    logic        move_class;
    logic        in_repeat;
    logic [3:0]  repeat_edge;
  } psda_req_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [23:0] addr;
    logic [23:0] wdata;
    logic [2:0]  lanes;
  } psda_pm_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } psda_dm_t;

endpackage : psda_pkg

// File: psda_bridge.sv
// program space data access bridge: table, remap and fetch paths
`timescale 1ns/1ps
`include "psda_map.svh"

module psda_bridge #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input  wire logic             CLK_IN,
  input  wire logic             ARST_N_IN,
  // register port
  input  wire logic [3:0]       REG_ADDR_IN,
  input  wire logic [15:0]      REG_WDATA_IN,
  input  wire logic             REG_WR_IN,
  input  wire logic             REG_RD_IN,
  output logic      [15:0]      REG_RDATA_OUT,
  // core request and answer
  input  wire psda_pkg::psda_req_t CORE_REQ_IN,
  output logic                  CORE_READY_OUT,
  output logic                  CORE_DONE_OUT,
  output logic      [15:0]      CORE_RDATA_OUT,
  output logic      [23:0]      CORE_INSTR_OUT,
  // program memory array
  output psda_pkg::psda_pm_t    PM_OUT,
  input  wire logic [23:0]      PM_RDATA_IN,
  // data memory
  output psda_pkg::psda_dm_t    DM_OUT,
  input  wire logic [15:0]      DM_RDATA_IN
);

  typedef struct packed {
    psda_pkg::psda_fsm_t fsm;
    psda_pkg::psda_op_t  op;
    logic [7:0]          table_page;
    logic [7:0]          remap_page;
    logic                remap_enable;
    psda_pkg::psda_pm_t  pm;
    psda_pkg::psda_dm_t  dm;
    logic                remap;
    logic                second_fetch;
    logic [1:0]          stall;
    logic                byte_mode;
    logic                byte_sel;
    logic                cfg_space;
    logic                from_dm;
    logic [15:0]         rdata;
    logic [23:0]         instr;
    logic                done;
    logic [15:0]         reg_rdata;
    logic [CNT_W-1:0]    remap_count;
  } psda_state_t;

  psda_state_t state;
  psda_state_t next_state;

  logic        table_op;
  logic        table_busy;
  logic        remap_hit;
  logic [1:0]  extra;
  logic        edge_iter;
  logic [23:0] table_addr;
  logic [23:0] remap_addr;
  logic [23:0] fetch_addr;
  logic [15:0] status_word;
  logic [15:0] low_word;
  logic [7:0]  high_byte;
  logic [7:0]  count_field;
  logic        byte_sel;
  logic        table_read;
  logic        data_read;
  logic [14:0] window_offset;

  assign table_op = (CORE_REQ_IN.op == psda_pkg::OP_TABLE_READ_LOW)
                 || (CORE_REQ_IN.op == psda_pkg::OP_TABLE_READ_HIGH)
                 || (CORE_REQ_IN.op == psda_pkg::OP_TABLE_WRITE_LOW)
                 || (CORE_REQ_IN.op == psda_pkg::OP_TABLE_WRITE_HIGH);

  assign table_read = (CORE_REQ_IN.op == psda_pkg::OP_TABLE_READ_LOW)
                   || (CORE_REQ_IN.op == psda_pkg::OP_TABLE_READ_HIGH);

  assign data_read = (CORE_REQ_IN.op == psda_pkg::OP_DATA_READ);

  // byte select is the lowest effective address bit for every byte access
  assign byte_sel = CORE_REQ_IN.ea[0];

  // a table access still in flight holds the remap path off
  assign table_busy = (state.fsm != psda_pkg::ST_IDLE) && !state.remap
                   && !state.from_dm && (state.op != psda_pkg::OP_FETCH);

  assign remap_hit = state.remap_enable
                  && CORE_REQ_IN.ea[`PSDA_BIT_EA_TOP]
                  && !table_busy;

  assign table_addr = {state.table_page, CORE_REQ_IN.ea};

  // ea top bit only opens the window, so it never reaches the address
  assign window_offset = CORE_REQ_IN.ea[14:0];

  // ea top bit is dropped; remap page bit 0 lands on address bit 15
  assign remap_addr = {1'b0,
                       state.remap_page,
                       window_offset};

  // fetches can never land in configuration space
  assign fetch_addr = {1'b0, CORE_REQ_IN.pc[22:1], 1'b0};

  assign edge_iter = |CORE_REQ_IN.repeat_edge;

  // stall cost follows the instruction class and loop position only
  always_comb begin
    if (CORE_REQ_IN.in_repeat) begin
      extra = edge_iter ? `PSDA_EXTRA_REP_EDGE
                        : `PSDA_EXTRA_REP_INNER;
    end else begin
      extra = CORE_REQ_IN.move_class ? `PSDA_EXTRA_MOVE
                                     : `PSDA_EXTRA_OTHER;
    end
  end

  // both halves are taken from one answer; remap uses only the low word
  assign low_word  = PM_RDATA_IN[15:0];
  assign high_byte = PM_RDATA_IN[23:16];

  // the status field is eight bits whatever width the counter is built at
  generate
    if (CNT_W >= 8) begin : g_count_cut
      assign count_field = state.remap_count[7:0];
    end else begin : g_count_pad
      assign count_field = {{(8 - CNT_W){1'b0}}, state.remap_count};
    end
  endgenerate

  // busy and done let software watch an access without a core probe
  assign status_word = {count_field,
                        4'h0,
                        state.remap,
                        state.cfg_space,
                        state.done,
                        (state.fsm != psda_pkg::ST_IDLE)};

  always_comb begin
    next_state = state;
    next_state.done = 1'b0;
    next_state.pm.rd = 1'b0;
    next_state.pm.wr = 1'b0;
    next_state.dm.rd = 1'b0;
    next_state.dm.wr = 1'b0;

    // register port: write takes effect from the next edge, read answers next cycle
    if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        `PSDA_OFS_TABLE_PAGE: begin
          next_state.table_page = REG_WDATA_IN[7:0];
        end
        `PSDA_OFS_REMAP_PAGE: begin
          next_state.remap_page = REG_WDATA_IN[7:0];
        end
        `PSDA_OFS_CORE_CONTROL: begin
          next_state.remap_enable = REG_WDATA_IN[`PSDA_BIT_REMAP_ENABLE];
        end
        default: begin
        end
      endcase
    end
    next_state.reg_rdata = 16'h0000;
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        `PSDA_OFS_TABLE_PAGE: begin
          next_state.reg_rdata = {8'h00, state.table_page};
        end
        `PSDA_OFS_REMAP_PAGE: begin
          next_state.reg_rdata = {8'h00, state.remap_page};
        end
        `PSDA_OFS_CORE_CONTROL: begin
          next_state.reg_rdata[`PSDA_BIT_REMAP_ENABLE] = state.remap_enable;
        end
        `PSDA_OFS_STATUS: begin
          next_state.reg_rdata = status_word;
        end
        default: begin
          next_state.reg_rdata = 16'h0000;
        end
      endcase
    end

    case (state.fsm)
      psda_pkg::ST_IDLE: begin
        if (CORE_REQ_IN.valid) begin
          next_state.op           = CORE_REQ_IN.op;
          next_state.byte_mode    = CORE_REQ_IN.byte_mode;
          next_state.byte_sel     = byte_sel;
          next_state.remap        = 1'b0;
          next_state.from_dm      = 1'b0;
          next_state.second_fetch = 1'b0;
          next_state.stall        = 2'h0;
          next_state.fsm          = psda_pkg::ST_ISSUE;
          if (CORE_REQ_IN.op == psda_pkg::OP_FETCH) begin
            next_state.pm.rd   = 1'b1;
            next_state.pm.addr = fetch_addr;
          end else if (table_op) begin
            next_state.pm.addr  = table_addr;
            next_state.cfg_space =
              state.table_page[`PSDA_BIT_PAGE_TOP];
            next_state.pm.rd = table_read;
            next_state.pm.wr = !table_read;
            // the low data byte is copied to every lane a byte may target
            next_state.pm.wdata = {CORE_REQ_IN.wdata[7:0],
                                   CORE_REQ_IN.wdata};
            next_state.pm.lanes = `PSDA_LANE_NONE;
            if (CORE_REQ_IN.op == psda_pkg::OP_TABLE_WRITE_LOW) begin
              if (!CORE_REQ_IN.byte_mode) begin
                next_state.pm.lanes = `PSDA_LANE_WORD;
              end else if (byte_sel) begin
                next_state.pm.wdata[15:8] = CORE_REQ_IN.wdata[7:0];
                next_state.pm.lanes = `PSDA_LANE_MID;
              end else begin
                next_state.pm.lanes = `PSDA_LANE_LOW;
              end
            end else if (CORE_REQ_IN.op ==
                         psda_pkg::OP_TABLE_WRITE_HIGH) begin
              // the phantom byte has no storage behind it
              if (!(CORE_REQ_IN.byte_mode && byte_sel)) begin
                next_state.pm.lanes = `PSDA_LANE_HIGH;
              end
            end
          end else if (remap_hit) begin
            next_state.remap    = 1'b1;
            next_state.cfg_space = 1'b0;
            next_state.pm.addr  = remap_addr;
            if (data_read) begin
              next_state.pm.rd = 1'b1;
              // the count wraps; it is an activity gauge, not an exact tally
              next_state.remap_count =
                state.remap_count + {{(CNT_W-1){1'b0}}, 1'b1};
              // second fetch only where the access costs a cycle
              if (extra != 2'h0) begin
                next_state.second_fetch = 1'b1;
                next_state.stall = extra - 2'h1;
              end
            end
            // the window is read only: a write there is dropped
          end else begin
            next_state.from_dm  = 1'b1;
            next_state.dm.addr  = CORE_REQ_IN.ea;
            next_state.dm.wdata = CORE_REQ_IN.wdata;
            next_state.dm.rd = data_read;
            next_state.dm.wr = (CORE_REQ_IN.op == psda_pkg::OP_DATA_WRITE);
          end
        end
      end

      psda_pkg::ST_ISSUE: begin
        // the repeat strobe fetches the same word again; its answer counts
        if (state.second_fetch) begin
          next_state.second_fetch = 1'b0;
          next_state.pm.rd = 1'b1;
        end else if (state.pm.wr || state.dm.wr
                  || (state.remap && !state.pm.rd)) begin
          next_state.done = 1'b1;
          next_state.fsm  = psda_pkg::ST_IDLE;
        end else begin
          next_state.fsm = psda_pkg::ST_CAPTURE;
        end
      end

      psda_pkg::ST_CAPTURE: begin
        // memory answers only the cycle after its strobe, so capture is fixed
        if (state.from_dm) begin
          next_state.rdata = DM_RDATA_IN;
        end else begin
          case (state.op)
            psda_pkg::OP_FETCH: begin
              next_state.instr = PM_RDATA_IN;
            end
            psda_pkg::OP_TABLE_READ_LOW: begin
              if (!state.byte_mode) begin
                next_state.rdata = low_word;
              end else if (state.byte_sel) begin
                next_state.rdata = {8'h00, low_word[15:8]};
              end else begin
                next_state.rdata = {8'h00, low_word[7:0]};
              end
            end
            psda_pkg::OP_TABLE_READ_HIGH: begin
              if (!state.byte_mode) begin
                next_state.rdata = {8'h00, high_byte};
              end else if (state.byte_sel) begin
                next_state.rdata = 16'h0000;
              end else begin
                next_state.rdata = {8'h00, high_byte};
              end
            end
            default: begin
              // remap hands back only the low program word
              next_state.rdata = low_word;
            end
          endcase
        end
        if (state.stall != 2'h0) begin
          next_state.fsm = psda_pkg::ST_STALL;
        end else begin
          next_state.done = 1'b1;
          next_state.fsm  = psda_pkg::ST_IDLE;
        end
      end

      psda_pkg::ST_STALL: begin
        // stall only stretches done; the read data is already held
        if (state.stall == 2'h1) begin
          next_state.stall = 2'h0;
          next_state.done  = 1'b1;
          next_state.fsm   = psda_pkg::ST_IDLE;
        end else begin
          next_state.stall = state.stall - 2'h1;
        end
      end

      default: begin
        next_state.fsm = psda_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      // every reset returns the pages and the enable to their defaults
      state              <= '0;
      state.fsm          <= psda_pkg::ST_IDLE;
      state.op           <= psda_pkg::OP_FETCH;
      state.table_page   <= `PSDA_RST_TABLE_PAGE;
      state.remap_page   <= `PSDA_RST_REMAP_PAGE;
      state.remap_enable <= `PSDA_RST_REMAP_ENABLE;
    end else begin
      state <= next_state;
    end
  end

  // a new request is only taken between accesses
  assign CORE_READY_OUT = (state.fsm == psda_pkg::ST_IDLE);
  assign CORE_DONE_OUT  = state.done;
  assign CORE_RDATA_OUT = state.rdata;
  assign CORE_INSTR_OUT = state.instr;
  assign REG_RDATA_OUT  = state.reg_rdata;
  assign PM_OUT         = state.pm;
  assign DM_OUT         = state.dm;

endmodule : psda_bridge

// File: psda_bridge_properties.sv
// port assertions for the program space data access bridge
`timescale 1ns/1ps
module psda_bridge_properties #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic                CLK_IN,
  input wire logic                ARST_N_IN,
  // register writes, for the page shadows
  input wire logic [3:0]          REG_ADDR_IN,
  input wire logic [15:0]         REG_WDATA_IN,
  input wire logic                REG_WR_IN,
  // core side
  input wire psda_pkg::psda_req_t CORE_REQ_IN,
  input wire logic                CORE_READY_OUT,
  input wire logic                CORE_DONE_OUT,
  input wire logic [15:0]         CORE_RDATA_OUT,
  // memories
  input wire psda_pkg::psda_pm_t  PM_OUT,
  input wire logic [23:0]         PM_RDATA_IN,
  input wire psda_pkg::psda_dm_t  DM_OUT
);
  logic [7:0] tp;
  logic [7:0] rp;
  logic       re;
  // shadows follow the writes so the checks need no internal probes
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      tp <= 8'h00;
      rp <= 8'h00;
      re <= 1'b0;
    end else if (REG_WR_IN) begin
      if (REG_ADDR_IN == 4'h0) tp <= REG_WDATA_IN[7:0];
      if (REG_ADDR_IN == 4'h4) rp <= REG_WDATA_IN[7:0];
      if (REG_ADDR_IN == 4'h8) re <= REG_WDATA_IN[2];
    end
  end
  wire       tk = CORE_REQ_IN.valid && CORE_READY_OUT;
  wire [2:0] op = CORE_REQ_IN.op;
  wire       dr = tk && op == psda_pkg::OP_DATA_READ;
  wire       dw = tk && op == psda_pkg::OP_DATA_WRITE;
  wire       rm = dr && CORE_REQ_IN.ea[15] && re;
  wire       tb = tk && op >= psda_pkg::OP_TABLE_READ_LOW
                  && op <= psda_pkg::OP_TABLE_WRITE_HIGH;
  wire       mv = !CORE_REQ_IN.in_repeat && CORE_REQ_IN.move_class;
  wire       inr = CORE_REQ_IN.in_repeat && !(|CORE_REQ_IN.repeat_edge);
  wire       lw = tk && op == psda_pkg::OP_TABLE_READ_LOW
                  && !CORE_REQ_IN.byte_mode;
  wire       hw = tk && op == psda_pkg::OP_TABLE_READ_HIGH
                  && !CORE_REQ_IN.byte_mode;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);
  table_addr_a: assert property (
    tb |=> (PM_OUT.rd || PM_OUT.wr)
           && PM_OUT.addr == {$past(tp), $past(CORE_REQ_IN.ea)})
    else $error("table address wrong");
  remap_addr_a: assert property (
    rm |=> PM_OUT.rd && !DM_OUT.rd
           && PM_OUT.addr == {1'b0, $past(rp), $past(CORE_REQ_IN.ea[14:0])})
    else $error("remap address wrong");
  two_fetch_a: assert property (
    rm && !inr |=> PM_OUT.rd ##1 PM_OUT.rd)
    else $error("remap read not fetched twice");
  move_wait_a: assert property (
    rm && mv |=> !CORE_DONE_OUT [*3] ##1 CORE_DONE_OUT)
    else $error("move remap stall wrong");
  other_wait_a: assert property (
    rm && !mv && !inr |=> !CORE_DONE_OUT [*4] ##1 CORE_DONE_OUT)
    else $error("two cycle remap stall wrong");
  inner_wait_a: assert property (
    rm && inr |=> !CORE_DONE_OUT [*2] ##1 CORE_DONE_OUT)
    else $error("inner repeat stall wrong");
  plain_data_a: assert property (
    dr && !rm |=> DM_OUT.rd && !PM_OUT.rd ##1 !PM_OUT.rd ##1 CORE_DONE_OUT)
    else $error("plain data access wrong");
  fetch_addr_a: assert property (
    tk && op == psda_pkg::OP_FETCH |=> PM_OUT.rd
      && PM_OUT.addr == {1'b0, $past(CORE_REQ_IN.pc[22:1]), 1'b0})
    else $error("fetch address wrong");
  low_word_a: assert property (
    CORE_DONE_OUT && $past(lw, 3) |->
      CORE_RDATA_OUT == $past(PM_RDATA_IN[15:0]))
    else $error("low word read wrong");
  high_word_a: assert property (
    CORE_DONE_OUT && $past(hw, 3) |->
      CORE_RDATA_OUT == {8'h00, $past(PM_RDATA_IN[23:16])})
    else $error("high word read wrong");
  data_write_a: assert property (
    dw && !(CORE_REQ_IN.ea[15] && re) |=> DM_OUT.wr && !PM_OUT.wr
      && DM_OUT.addr == $past(CORE_REQ_IN.ea)
      && DM_OUT.wdata == $past(CORE_REQ_IN.wdata) ##1 CORE_DONE_OUT)
    else $error("plain data write wrong");
endmodule : psda_bridge_properties

bind psda_bridge psda_bridge_properties #(.CNT_W(CNT_W)) u_props (
  .CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN),
  .CORE_REQ_IN(CORE_REQ_IN), .CORE_READY_OUT(CORE_READY_OUT),
  .CORE_DONE_OUT(CORE_DONE_OUT), .CORE_RDATA_OUT(CORE_RDATA_OUT),
  .PM_OUT(PM_OUT), .PM_RDATA_IN(PM_RDATA_IN), .DM_OUT(DM_OUT));

// File: psda_mem_model.sv
// program and data memory model, answering one cycle after a read
`timescale 1ns/1ps
module psda_mem_model (
  // clock and reset
  input  wire logic               clk_in,
  input  wire logic               arst_n_in,
  // requests
  input  wire psda_pkg::psda_pm_t pm_in,
  input  wire psda_pkg::psda_dm_t dm_in,
  // answers
  output logic [23:0]             pm_rdata_out,
  output logic [15:0]             dm_rdata_out
);
  // answer stands one cycle, then the lines toggle instead of holding
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pm_rdata_out <= 24'h000000;
      dm_rdata_out <= 16'h0000;
    end else begin
      pm_rdata_out <= pm_in.rd ? {pm_in.addr[7:0] ^ pm_in.addr[23:16],
                      pm_in.addr[15:0] ^ 16'hC35A} : ~pm_rdata_out;
      dm_rdata_out <= dm_in.rd ? dm_in.addr ^ 16'h9E37 : ~dm_rdata_out;
    end
  end
endmodule : psda_mem_model

// File: psda_bridge_tb.sv
// self-checking bench for the program space data access bridge
`timescale 1ns/1ps
module psda_bridge_tb;
  typedef struct packed {
    logic [1:0]  k;
    logic [23:0] v;
    logic [23:0] m;
  } psda_exp_t;
  logic                CLK_IN = 1'b0;
  logic                ARST_N_IN = 1'b0;
  logic [3:0]          REG_ADDR_IN = 4'h0;
  logic [15:0]         REG_WDATA_IN = 16'h0000;
  logic                REG_WR_IN = 1'b0;
  logic                REG_RD_IN = 1'b0;
  logic [15:0]         REG_RDATA_OUT;
  psda_pkg::psda_req_t CORE_REQ_IN = '0;
  logic                CORE_READY_OUT;
  logic                CORE_DONE_OUT;
  logic [15:0]         CORE_RDATA_OUT;
  logic [23:0]         CORE_INSTR_OUT;
  psda_pkg::psda_pm_t  PM_OUT;
  logic [23:0]         PM_RDATA_IN;
  psda_pkg::psda_dm_t  DM_OUT;
  logic [15:0]         DM_RDATA_IN;
  int                  errors = 0;
  int                  checks = 0;
  int                  cyc = 0;
  logic [31:0]         seed = 32'h00000B16;
  logic [31:0]         t;
  logic [23:0]         w;
  logic [15:0]         a;
  logic [7:0]          tp;
  logic [7:0]          rp;
  logic [22:0]         pc = 23'h000000;
  logic                mc = 1'b0;
  logic                ir = 1'b0;
  logic [3:0]          ed = 4'h0;
  logic                rd_d = 1'b0;
  psda_exp_t           e;
  psda_exp_t           x;
  psda_exp_t           cq[$];
  logic [15:0]         rq[$];

  psda_bridge uut (
    .CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .REG_ADDR_IN(REG_ADDR_IN),
    .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN),
    .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
    .CORE_REQ_IN(CORE_REQ_IN), .CORE_READY_OUT(CORE_READY_OUT),
    .CORE_DONE_OUT(CORE_DONE_OUT), .CORE_RDATA_OUT(CORE_RDATA_OUT),
    .CORE_INSTR_OUT(CORE_INSTR_OUT), .PM_OUT(PM_OUT),
    .PM_RDATA_IN(PM_RDATA_IN), .DM_OUT(DM_OUT), .DM_RDATA_IN(DM_RDATA_IN));
  psda_mem_model mem (
    .clk_in(CLK_IN), .arst_n_in(ARST_N_IN), .pm_in(PM_OUT), .dm_in(DM_OUT),
    .pm_rdata_out(PM_RDATA_IN), .dm_rdata_out(DM_RDATA_IN));

  initial forever #10 CLK_IN = ~CLK_IN;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [23:0] pmw(input logic [23:0] p);
    return {p[7:0] ^ p[23:16], p[15:0] ^ 16'hC35A};
  endfunction : pmw

  task chk(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge CLK_IN);
    REG_ADDR_IN <= ad;
    REG_WDATA_IN <= d;
    REG_WR_IN <= 1'b1;
    @(posedge CLK_IN);
    REG_WR_IN <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] ad, input logic [15:0] d);
    rq.push_back(d);
    @(posedge CLK_IN);
    REG_ADDR_IN <= ad;
    REG_RD_IN <= 1'b1;
    @(posedge CLK_IN);
    REG_RD_IN <= 1'b0;
  endtask : rd
  task go(input psda_pkg::psda_op_t op, input logic [15:0] ea,
          input logic bm, input psda_exp_t ex);
    int n;
    psda_pkg::psda_req_t r;
    r = '0;
    r.valid = 1'b1;
    r.op = op;
    r.ea = ea;
    r.pc = pc;
    r.wdata = 16'(xs());
    r.byte_mode = bm;
    r.move_class = mc;
    r.in_repeat = ir;
    r.repeat_edge = ed;
    cq.push_back(ex);
    @(posedge CLK_IN);
    CORE_REQ_IN <= r;
    @(posedge CLK_IN);
    CORE_REQ_IN.valid <= 1'b0;
    n = 0;
    do begin
      @(negedge CLK_IN);
      n++;
    end while (CORE_DONE_OUT !== 1'b1 && n < 16);
    if (n == 16) begin
      errors++;
      $display("ERROR %0t: no completion", $time);
    end
  endtask : go

  // results are taken mid-cycle, where registered outputs have settled
  always @(negedge CLK_IN) begin
    if (rd_d) chk({8'h00, REG_RDATA_OUT}, {8'h00, rq.pop_front()});
    rd_d = REG_RD_IN;
    if (CORE_DONE_OUT === 1'b1 && cq.size() > 0) begin
      e = cq.pop_front();
      if (e.k == 2'h1) chk(CORE_INSTR_OUT, e.v);
      else if (e.k == 2'h0)
        chk({8'h00, CORE_RDATA_OUT} & e.m, e.v);
    end
  end
  always @(posedge CLK_IN) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("ERROR %0t: timeout", $time);
      end_sim();
    end
  end

  initial begin
    repeat (4) @(posedge CLK_IN);
    ARST_N_IN <= 1'b1;
    for (int i = 0; i < 4; i++) rd(4'(2 * i + (i / 2) * 2), 16'h0000);
    $display("test reset values and unmapped read done");
    x.k = 2'h0;
    for (int i = 0; i < 16; i++) begin
      if (i % 4 == 0) begin
        t = xs();
        tp = {i[2], t[6:0]};
        wr(4'h0, {t[15:8], tp});
        rd(4'h0, {8'h00, tp});
      end
      t = xs();
      w = pmw({tp, t[15:0]});
      x.m = i[1] ? 24'h0000FF : 24'h00FFFF;
      if (!i[0]) x.v = i[1] ? {16'h0000, t[0] ? w[15:8] : w[7:0]}
                            : {8'h00, w[15:0]};
      else x.v = (i[1] && t[0]) ? 24'h000000 : {16'h0000, w[23:16]};
      go(i[0] ? psda_pkg::OP_TABLE_READ_HIGH : psda_pkg::OP_TABLE_READ_LOW,
         t[15:0], i[1], x);
    end
    x.k = 2'h2;
    go(psda_pkg::OP_TABLE_WRITE_LOW, 16'(xs()), 1'b0, x);
    go(psda_pkg::OP_TABLE_WRITE_HIGH, 16'(xs()), 1'b0, x);
    rd(4'hC, 16'h0004);
    $display("test table accesses done");
    t = xs();
    rp = t[7:0];
    wr(4'h4, {t[15:8], rp});
    rd(4'h4, {8'h00, rp});
    wr(4'h8, 16'h0004);
    x.k = 2'h0;
    x.m = 24'h00FFFF;
    for (int j = 0; j < 10; j++) begin
      mc = j[0];
      ir = j >= 4;
      ed = (j >= 4 && j < 8) ? 4'(1 << (j - 4)) : 4'h0;
      t = xs();
      w = pmw({1'b0, rp, t[14:0]});
      x.v = {8'h00, w[15:0]};
      go(psda_pkg::OP_DATA_READ, {1'b1, t[14:0]}, 1'b0, x);
    end
    {mc, ir, ed} = 6'h00;
    rd(4'hC, 16'h0A08);
    x.k = 2'h2;
    go(psda_pkg::OP_DATA_WRITE, 16'h8000 | 16'(xs()), 1'b0, x);
    x.k = 2'h0;
    $display("test remapped reads done");
    for (int j = 0; j < 2; j++) begin
      if (j == 1) wr(4'h8, 16'h0000);
      t = xs();
      a = {j[0], t[14:0]};
      x.v = {8'h00, a ^ 16'h9E37};
      go(psda_pkg::OP_DATA_READ, a, 1'b0, x);
      x.k = 2'h2;
      go(psda_pkg::OP_DATA_WRITE, a, 1'b0, x);
      x.k = 2'h0;
    end
    $display("test plain data reads done");
    x.k = 2'h1;
    for (int j = 0; j < 4; j++) begin
      pc = 23'(xs());
      x.v = pmw({1'b0, pc[22:1], 1'b0});
      go(psda_pkg::OP_FETCH, 16'h0000, 1'b0, x);
    end
    $display("test fetches done");
    @(posedge CLK_IN);
    ARST_N_IN <= 1'b0;
    repeat (2) @(posedge CLK_IN);
    ARST_N_IN <= 1'b1;
    rd(4'h4, 16'h0000);
    rd(4'hC, 16'h0000);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule : psda_bridge_tb
